// *** design/omf_microword.sv ***
/*
 * Option microword control: option microword register, phase-gated control
 * strobes, microbus drive toward the host, return-bus drivers and the
 * floating holding registers.
 * Assumes the host phase pulses, cycle end and microword clock are one-cycle
 * pulses produced on ref_clk by the host timing logic.
 */
// Behaviour
// - 24-bit microword registered from option store
// - Pointer bit 8 enable in own flip-flop
// - Store outputs enabled only by store select
// - No clear; load only on microword clock
// - Count step needs cycle end pulse
// - Count load needs phase one or two
// - Three-bit code field decoded for functions
// - Carry, overflow, neg/zero clock enables
// - Neg/zero and carry/overflow mux selects
// - Divisor register shift, load or hold
// - Read select plus strobe onto return bus
// - Page bit set: option drives microbus
// - Unproduced microbus bits driven low
// - 44 active-low open-collector lines; host terminates
// - Second argument pass forces even register
// - Holding registers load from buffer register
// - Holding registers step on phase one/two
// - Low register follows select when gated
// - Right shift: high bit 0 into low bit 15
// - Left: carry into low; right: divisor into high
// - High left input is low bit 15 on code 5
`timescale 1ns/1ps

module omf_microword (
	input  wire logic                ref_clk,
	input  wire logic                resetn,
	input  wire logic                phase_p1,
	input  wire logic                phase_p2,
	input  wire logic                phase_p3,
	input  wire logic                cycle_end_pulse,
	input  wire logic                microword_clock,
	input  wire logic                microprogram_page_bit,
	input  wire omf_pkg::omf_mword_t ustore_data,
	input  wire logic                ustore_bit8_enable,
	input  wire logic [2:0]          fp_store_data,
	input  wire omf_pkg::omf_ubus_t  host_format_word,
	input  wire logic                argument_even_force,
	input  wire omf_pkg::omf_data_t  read_word,
	input  wire omf_pkg::omf_data_t  option_buffer_register,
	input  wire logic                external_carry_flag,
	input  wire logic                divisor_bit0,
	output logic                     option_store_select,
	output logic                     pointer_bit8_clock_enable,
	output logic                     pointer_bit8_clock,
	output logic [3:0]               external_branch_field,
	output logic                     buffer_clock,
	output logic                     count_step,
	output logic                     count_load,
	output logic [7:0]               code_decode,
	output logic                     carry_flag_clock,
	output logic                     overflow_flag_clock,
	output logic                     neg_zero_flag_clock,
	output logic [1:0]               neg_zero_mux_select,
	output logic [2:0]               carry_overflow_mux_select,
	output omf_pkg::omf_shift_t      divisor_reg_select,
	output logic [1:0]               read_mux_select,
	output logic                     read_mux_strobe,
	output omf_pkg::omf_data_t       bus_rd_n_o,
	output omf_pkg::omf_data_t       bus_rd_n_oe,
	output omf_pkg::omf_ubus_t       bus_u_n_o,
	output omf_pkg::omf_ubus_t       bus_u_n_oe,
	output omf_pkg::omf_data_t       fp_high_shift_reg,
	output omf_pkg::omf_data_t       fp_low_shift_reg
);
	import omf_pkg::*;

	// One-hot decode of the general-purpose code field
	function automatic logic [7:0] code_onehot(input logic [2:0] code);
		code_onehot = 8'h01 << code;
	endfunction : code_onehot

	localparam logic MICROWORD_CLEAR = 1'b0;

	omf_mword_t mw_d;
	omf_mword_t mw_q;
	logic [2:0] fpw_d;
	logic [2:0] fpw_q;
	logic       bit8en_d;
	logic       bit8en_q;
	logic       sel_d;
	logic       sel_q;
	logic       ph12;
	logic       mw_load;
	logic [7:0] code_dec;

	// Option microword and its discrete pointer-bit flip-flop
	always_comb begin
		sel_d    = microprogram_page_bit;
		mw_load  = microword_clock & sel_q & !MICROWORD_CLEAR;
		mw_d     = mw_q;
		fpw_d    = fpw_q;
		bit8en_d = bit8en_q;
		if (mw_load) begin
			mw_d     = ustore_data;
			fpw_d    = fp_store_data;
			bit8en_d = ustore_bit8_enable;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sel_q    <= 1'b0;
			mw_q     <= `OMF_MW_RESET;
			fpw_q    <= 3'h0;
			bit8en_q <= 1'b0;
		end else begin
			sel_q    <= sel_d;
			mw_q     <= mw_d;
			fpw_q    <= fpw_d;
			bit8en_q <= bit8en_d;
		end
	end

	assign ph12     = phase_p1 | phase_p2;
	assign code_dec = code_onehot(mw_q[`OMF_CODE_MSB:`OMF_CODE_LSB]);

	// Registered control strobes and fields
	logic       b8clk_d, bufclk_d, step_d, load_d, cclk_d, vclk_d, nzclk_d, strobe_d;
	logic       b8clk_q, bufclk_q, step_q, load_q, cclk_q, vclk_q, nzclk_q, strobe_q;
	logic [3:0] branch_d, branch_q;
	logic [7:0] dec_d, dec_q;
	logic [1:0] nzsel_d, nzsel_q, rdsel_d, rdsel_q;
	logic [2:0] cvsel_d, cvsel_q;
	omf_shift_t divsel_d, divsel_q;

	always_comb begin
		b8clk_d  = bit8en_q & microword_clock;
		bufclk_d = mw_q[`OMF_BUF_CLK_EN] & phase_p3;
		step_d   = mw_q[`OMF_CNT_STEP_EN] & cycle_end_pulse;
		load_d   = mw_q[`OMF_CNT_LOAD_EN] & ph12;
		cclk_d   = mw_q[`OMF_CARRY_CLK_EN] & ph12;
		vclk_d   = mw_q[`OMF_OVFL_CLK_EN] & ph12;
		nzclk_d  = mw_q[`OMF_NZ_CLK_EN] & ph12;
		branch_d = mw_q[`OMF_BRANCH_MSB:`OMF_BRANCH_LSB];
		dec_d    = code_dec;
		nzsel_d  = mw_q[`OMF_NZ_SEL_MSB:`OMF_NZ_SEL_LSB];
		cvsel_d  = mw_q[`OMF_CV_SEL_MSB:`OMF_CV_SEL_LSB];
		divsel_d = omf_shift_t'(mw_q[`OMF_DIV_SEL_MSB:`OMF_DIV_SEL_LSB]);
		rdsel_d  = mw_q[`OMF_RD_SEL_MSB:`OMF_RD_SEL_LSB];
		strobe_d = mw_q[`OMF_RD_STROBE];
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			b8clk_q  <= 1'b0;
			bufclk_q <= 1'b0;
			step_q   <= 1'b0;
			load_q   <= 1'b0;
			cclk_q   <= 1'b0;
			vclk_q   <= 1'b0;
			nzclk_q  <= 1'b0;
			branch_q <= 4'h0;
			dec_q    <= 8'h00;
			nzsel_q  <= 2'h0;
			cvsel_q  <= 3'h0;
			divsel_q <= OMF_HOLD;
			rdsel_q  <= 2'h0;
			strobe_q <= 1'b0;
		end else begin
			b8clk_q  <= b8clk_d;
			bufclk_q <= bufclk_d;
			step_q   <= step_d;
			load_q   <= load_d;
			cclk_q   <= cclk_d;
			vclk_q   <= vclk_d;
			nzclk_q  <= nzclk_d;
			branch_q <= branch_d;
			dec_q    <= dec_d;
			nzsel_q  <= nzsel_d;
			cvsel_q  <= cvsel_d;
			divsel_q <= divsel_d;
			rdsel_q  <= rdsel_d;
			strobe_q <= strobe_d;
		end
	end

	// Open-collector drivers: a line is pulled low where the enable is set
	omf_ubus_t ubus_oe_d, ubus_oe_q;
	omf_data_t rd_oe_d, rd_oe_q;

	always_comb begin
		ubus_oe_d = '0;
		if (microprogram_page_bit) begin
			ubus_oe_d = ~(host_format_word & `OMF_UBUS_ACTIVE);
			if (argument_even_force)
				ubus_oe_d[`OMF_UBUS_REG_LSB] = 1'b1;
		end
		rd_oe_d = strobe_q ? read_word : '0;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ubus_oe_q <= '0;
			rd_oe_q   <= '0;
		end else begin
			ubus_oe_q <= ubus_oe_d;
			rd_oe_q   <= rd_oe_d;
		end
	end

	// Floating holding registers
	omf_fp_if fp_bus ();

	assign fp_bus.step      = ph12;
	assign fp_bus.hi_sel    = omf_shift_t'(fpw_q[`OMF_HI_SEL_MSB:`OMF_HI_SEL_LSB]);
	assign fp_bus.lo_gate   = fpw_q[`OMF_LO_GATE];
	assign fp_bus.load_data = option_buffer_register;
	assign fp_bus.carry_in  = external_carry_flag;
	assign fp_bus.div_bit0  = divisor_bit0;
	assign fp_bus.code_link = code_dec[`OMF_CODE_LINK];

	omf_fp_shift_regs u_fp (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.fp      (fp_bus)
	);

	assign option_store_select       = sel_q;
	assign pointer_bit8_clock_enable = bit8en_q;
	assign pointer_bit8_clock        = b8clk_q;
	assign external_branch_field     = branch_q;
	assign buffer_clock              = bufclk_q;
	assign count_step                = step_q;
	assign count_load                = load_q;
	assign code_decode               = dec_q;
	assign carry_flag_clock          = cclk_q;
	assign overflow_flag_clock       = vclk_q;
	assign neg_zero_flag_clock       = nzclk_q;
	assign neg_zero_mux_select       = nzsel_q;
	assign carry_overflow_mux_select = cvsel_q;
	assign divisor_reg_select        = divsel_q;
	assign read_mux_select           = rdsel_q;
	assign read_mux_strobe           = strobe_q;
	assign bus_rd_n_o                = '0;
	assign bus_rd_n_oe               = rd_oe_q;
	assign bus_u_n_o                 = '0;
	assign bus_u_n_oe                = ubus_oe_q;
	assign fp_high_shift_reg         = fp_bus.hi_reg;
	assign fp_low_shift_reg          = fp_bus.lo_reg;

	// Checks
	sequence s_word_load;
		microword_clock && sel_q;
	endsequence

	AST_MW_LOAD: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_word_load ##1 1'b1 ##1 1'b1 |-> mw_q == $past(ustore_data, 2) || $past(mw_load))
		else $error("Microword not taken from the store");
	AST_MW_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
		!mw_load |=> mw_q == $past(mw_q) && bit8en_q == $past(bit8en_q))
		else $error("Microword changed without its clock");
	AST_STORE_SEL: assert property (@(posedge ref_clk) disable iff (!resetn)
		option_store_select == $past(microprogram_page_bit))
		else $error("Store select does not follow page bit");
	AST_STEP: assert property (@(posedge ref_clk) disable iff (!resetn)
		count_step |-> $past(cycle_end_pulse) && $past(mw_q[`OMF_CNT_STEP_EN]))
		else $error("Count step without cycle end");
	AST_LOAD: assert property (@(posedge ref_clk) disable iff (!resetn)
		count_load == $past(mw_q[`OMF_CNT_LOAD_EN] & (phase_p1 | phase_p2)))
		else $error("Count load not gated by phases");
	AST_CARRY: assert property (@(posedge ref_clk) disable iff (!resetn)
		carry_flag_clock |-> $past(phase_p1 | phase_p2))
		else $error("Carry clock outside phase one/two");
	AST_DECODE: assert property (@(posedge ref_clk) disable iff (!resetn)
		$past(resetn) |-> $onehot(code_decode) && code_decode[$past(mw_q[`OMF_CODE_MSB:`OMF_CODE_LSB])])
		else $error("Code decode wrong");
	AST_UBUS_IDLE: assert property (@(posedge ref_clk) disable iff (!resetn)
		!$past(microprogram_page_bit) |-> bus_u_n_oe == '0)
		else $error("Microbus driven while option idle");
	AST_EVEN_FORCE: assert property (@(posedge ref_clk) disable iff (!resetn)
		microprogram_page_bit && argument_even_force |=> bus_u_n_oe[`OMF_UBUS_REG_LSB])
		else $error("Even register not forced");
	AST_RD_STROBE: assert property (@(posedge ref_clk) disable iff (!resetn)
		!read_mux_strobe |=> bus_rd_n_oe == '0)
		else $error("Return bus driven without strobe");
	AST_RD_DRIVE: assert property (@(posedge ref_clk) disable iff (!resetn)
		read_mux_strobe |=> bus_rd_n_oe == $past(read_word))
		else $error("Return bus does not carry the read word");
	AST_UNUSED_LOW: assert property (@(posedge ref_clk) disable iff (!resetn)
		microprogram_page_bit |=> (bus_u_n_oe & ~`OMF_UBUS_ACTIVE) == ~`OMF_UBUS_ACTIVE)
		else $error("Unproduced microbus line not pulled low");
	AST_OVFL: assert property (@(posedge ref_clk) disable iff (!resetn)
		overflow_flag_clock == $past(mw_q[`OMF_OVFL_CLK_EN] & (phase_p1 | phase_p2)))
		else $error("Overflow clock not gated by phases");
	AST_NZ: assert property (@(posedge ref_clk) disable iff (!resetn)
		neg_zero_flag_clock == $past(mw_q[`OMF_NZ_CLK_EN] & (phase_p1 | phase_p2)))
		else $error("Neg/zero clock not gated by phases");
	AST_PTR_CLK: assert property (@(posedge ref_clk) disable iff (!resetn)
		pointer_bit8_clock == $past(bit8en_q & microword_clock))
		else $error("Pointer bit clock not gated by its enable");
	AST_DIV_SEL: assert property (@(posedge ref_clk) disable iff (!resetn)
		divisor_reg_select == $past(mw_q[`OMF_DIV_SEL_MSB:`OMF_DIV_SEL_LSB]))
		else $error("Divisor select does not follow the microword");

endmodule : omf_microword

// *** shared/omf_defs.svh ***
/*
 * Constants of the option microword block: field positions of the 24-bit
 * option microword, the floating-point control word, microbus layout.
 * Assumes it is included by bare name from the package, which is compiled ahead of the design files.
 */
`ifndef OMF_DEFS_SVH
`define OMF_DEFS_SVH

`define OMF_MW_WIDTH        24
`define OMF_FPW_WIDTH       3
`define OMF_UBUS_WIDTH      44
`define OMF_DATA_WIDTH      16

// Option microword fields
`define OMF_BRANCH_LSB      0
`define OMF_BRANCH_MSB      3
`define OMF_BUF_CLK_EN      4
`define OMF_CNT_STEP_EN     5
`define OMF_CNT_LOAD_EN     6
`define OMF_CODE_LSB        7
`define OMF_CODE_MSB        9
`define OMF_CARRY_CLK_EN    10
`define OMF_OVFL_CLK_EN     11
`define OMF_NZ_CLK_EN       12
`define OMF_NZ_SEL_LSB      13
`define OMF_NZ_SEL_MSB      14
`define OMF_CV_SEL_LSB      15
`define OMF_CV_SEL_MSB      17
`define OMF_DIV_SEL_LSB     18
`define OMF_DIV_SEL_MSB     19
`define OMF_RD_SEL_LSB      20
`define OMF_RD_SEL_MSB      21
`define OMF_RD_STROBE       22

// Floating-point control word fields
`define OMF_HI_SEL_LSB      0
`define OMF_HI_SEL_MSB      1
`define OMF_LO_GATE         2

// Code that routes the low register top bit into the high register on a left shift
`define OMF_CODE_LINK       3'h5

// Microbus: register-address low bit, and the lines the option actively produces
`define OMF_UBUS_REG_LSB    9
`define OMF_UBUS_ACTIVE     44'h000_0000_FFFF

`define OMF_MW_RESET        24'h00_0000
`define OMF_DATA_RESET      16'h0000

`endif

// *** shared/omf_pkg.sv ***
/*
 * Types of the option microword block.
 * Assumes omf_defs.svh is reachable on the include path.
 */
`include "omf_defs.svh"

package omf_pkg;

	// Shift-register mode, encoded as the select pair of a universal shifter
	typedef enum logic [1:0] {
		OMF_HOLD,
		OMF_SHIFT_RIGHT,
		OMF_SHIFT_LEFT,
		OMF_LOAD
	} omf_shift_t;

	typedef logic [`OMF_MW_WIDTH-1:0]   omf_mword_t;
	typedef logic [`OMF_DATA_WIDTH-1:0] omf_data_t;
	typedef logic [`OMF_UBUS_WIDTH-1:0] omf_ubus_t;

endpackage : omf_pkg

// *** shared/omf_fp_if.sv ***
/*
 * Carrier between the microword control and the floating holding registers.
 * Assumes both ends run on the same ref_clk.
 */
`timescale 1ns/1ps

interface omf_fp_if;
	import omf_pkg::*;
	logic       step;
	omf_shift_t hi_sel;
	logic       lo_gate;
	omf_data_t  load_data;
	logic       carry_in;
	logic       div_bit0;
	logic       code_link;
	omf_data_t  hi_reg;
	omf_data_t  lo_reg;

	modport ctl  (output step, hi_sel, lo_gate, load_data, carry_in, div_bit0, code_link,
	              input hi_reg, lo_reg);
	modport regs (input step, hi_sel, lo_gate, load_data, carry_in, div_bit0, code_link,
	              output hi_reg, lo_reg);
endinterface : omf_fp_if

// *** design/omf_fp_shift_regs.sv ***
/*
 * Floating high and low 16-bit holding/shift registers.
 * Assumes the step strobe is the combined first/second phase pulse.
 */
`timescale 1ns/1ps

module omf_fp_shift_regs (
	input  wire logic ref_clk,
	input  wire logic resetn,
	omf_fp_if.regs    fp
);
	import omf_pkg::*;

	omf_data_t  hi_d;
	omf_data_t  lo_d;
	omf_data_t  hi_q;
	omf_data_t  lo_q;
	omf_shift_t lo_sel;

	always_comb begin
		lo_sel = fp.lo_gate ? fp.hi_sel : OMF_HOLD;
		hi_d   = hi_q;
		lo_d   = lo_q;
		if (fp.step) begin
			case (fp.hi_sel)
				OMF_LOAD:        hi_d = fp.load_data;
				OMF_SHIFT_RIGHT: hi_d = {fp.div_bit0, hi_q[15:1]};
				OMF_SHIFT_LEFT:  hi_d = {hi_q[14:0], fp.code_link & lo_q[15]};
				default:         hi_d = hi_q;
			endcase
			case (lo_sel)
				OMF_LOAD:        lo_d = fp.load_data;
				OMF_SHIFT_RIGHT: lo_d = {hi_q[0], lo_q[15:1]};
				OMF_SHIFT_LEFT:  lo_d = {lo_q[14:0], fp.carry_in};
				default:         lo_d = lo_q;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			hi_q <= `OMF_DATA_RESET;
			lo_q <= `OMF_DATA_RESET;
		end else begin
			hi_q <= hi_d;
			lo_q <= lo_d;
		end
	end

	assign fp.hi_reg = hi_q;
	assign fp.lo_reg = lo_q;

	AST_LO_UNGATED_HOLDS: assert property (@(posedge ref_clk) disable iff (!resetn)
		!fp.lo_gate |=> lo_q == $past(lo_q))
		else $error("Low register changed without its gate");

	AST_RIGHT_CHAIN: assert property (@(posedge ref_clk) disable iff (!resetn)
		fp.step && fp.lo_gate && fp.hi_sel == OMF_SHIFT_RIGHT
		|=> lo_q[15] == $past(hi_q[0]) && hi_q[15] == $past(fp.div_bit0))
		else $error("Right shift chain broken");

	AST_LEFT_LINK: assert property (@(posedge ref_clk) disable iff (!resetn)
		fp.step && fp.hi_sel == OMF_SHIFT_LEFT
		|=> hi_q[0] == ($past(fp.code_link) & $past(lo_q[15])))
		else $error("High register left-shift input wrong");

	AST_NO_STEP_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
		!fp.step |=> hi_q == $past(hi_q))
		else $error("High register changed without a phase clock");

endmodule : omf_fp_shift_regs

// *** tb/omf_host_model.sv ***
/*
 * Host-side model: four-step phase sequence, option microword clock and the
 * terminated microbus as the host sees it, combinationally.
 * Assumes the option pulls microbus lines low only, as open-collector drivers.
 */
`timescale 1ns/1ps

module omf_host_model #(
	parameter logic [43:0] HOST_PATTERN = 44'h5A5_A5A5_A5A5
) (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        microprogram_page_bit,
	input  wire logic [43:0] bus_u_n_o,
	input  wire logic [43:0] bus_u_n_oe,
	output logic             phase_p1,
	output logic             phase_p2,
	output logic             phase_p3,
	output logic             cycle_end_pulse,
	output logic             microword_clock,
	output logic [43:0]      host_uword
);
	logic [1:0] phase_q;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	assign phase_p1        = resetn && phase_q == 2'h0;
	assign phase_p2        = resetn && phase_q == 2'h1;
	assign phase_p3        = resetn && phase_q == 2'h2;
	assign cycle_end_pulse = resetn && phase_q == 2'h3;
	assign microword_clock = cycle_end_pulse;
	// Own store released while the page bit is set; terminators pull idle lines high
	assign host_uword = (microprogram_page_bit ? {44{1'h1}} : HOST_PATTERN)
	                    & ~(bus_u_n_oe & ~bus_u_n_o);
endmodule : omf_host_model

// *** tb/tb_top.sv ***
/*
 * Self-checking bench of the option microword block with its floating holding registers.
 * Assumes the host model supplies all phase timing.
 */
`timescale 1ns/1ps

module tb_top;
	import omf_pkg::*;
	localparam logic [43:0] HOST_PATTERN = 44'h5A5_A5A5_A5A5;
	typedef struct {
		logic [23:0] base;
		logic [2:0]  code;
		logic [2:0]  fp;
		logic [15:0] buf_v;
		logic        dbit;
		logic        cin;
		logic [15:0] hi;
		logic [15:0] lo;
	} omf_row_t;

	logic ref_clk = 1'h0, resetn, phase_p1, phase_p2, phase_p3, cycle_end_pulse, microword_clock;
	logic microprogram_page_bit, ustore_bit8_enable, argument_even_force, external_carry_flag, divisor_bit0;
	logic option_store_select, pointer_bit8_clock_enable, pointer_bit8_clock, buffer_clock, count_step;
	logic count_load, carry_flag_clock, overflow_flag_clock, neg_zero_flag_clock, read_mux_strobe;
	logic [3:0] external_branch_field;
	logic [7:0] code_decode;
	logic [1:0] neg_zero_mux_select, read_mux_select;
	logic [2:0] carry_overflow_mux_select, fp_store_data;
	omf_shift_t divisor_reg_select;
	omf_mword_t ustore_data;
	omf_ubus_t  host_format_word, bus_u_n_o, bus_u_n_oe, host_uword;
	omf_data_t  read_word, option_buffer_register, bus_rd_n_o, bus_rd_n_oe;
	omf_data_t  fp_high_shift_reg, fp_low_shift_reg;
	int num_errors = 0;
	int n_tests = 0;

	// Load both, load high alone, then shifts in each direction
	omf_row_t rows [0:7] = '{
		'{24'h00_0000, 3'h0, 3'h7, 16'hC3A5, 1'h0, 1'h0, 16'hC3A5, 16'hC3A5},
		'{24'h44_5C35, 3'h1, 3'h3, 16'h5A0F, 1'h0, 1'h0, 16'h5A0F, 16'hC3A5},
		'{24'h68_A812, 3'h3, 3'h5, 16'h1234, 1'h1, 1'h0, 16'hD683, 16'hF0E9},
		'{24'h3C_F470, 3'h5, 3'h6, 16'h8421, 1'h0, 1'h0, 16'h5A0F, 16'hC3A4},
		'{24'h7F_FC7F, 3'h2, 3'h6, 16'hFFFF, 1'h0, 1'h1, 16'h683C, 16'h0E93},
		'{24'h12_3400, 3'h4, 3'h4, 16'h0F0F, 1'h1, 1'h1, 16'h683C, 16'h0E93},
		'{24'h20_0000, 3'h6, 3'h3, 16'h0001, 1'h0, 1'h0, 16'h0001, 16'h0E93},
		'{24'h55_5455, 3'h7, 3'h1, 16'hA5A5, 1'h0, 1'h1, 16'h0000, 16'h0E93}
	};

	always #2 ref_clk = ~ref_clk;

	omf_host_model #(.HOST_PATTERN(HOST_PATTERN)) omf_host_model_i (.ref_clk, .resetn,
		.microprogram_page_bit, .bus_u_n_o, .bus_u_n_oe, .phase_p1, .phase_p2, .phase_p3,
		.cycle_end_pulse, .microword_clock, .host_uword);

	omf_microword omf_microword_i (.ref_clk, .resetn, .phase_p1, .phase_p2, .phase_p3,
		.cycle_end_pulse, .microword_clock, .microprogram_page_bit, .ustore_data, .ustore_bit8_enable,
		.fp_store_data, .host_format_word, .argument_even_force, .read_word, .option_buffer_register,
		.external_carry_flag, .divisor_bit0, .option_store_select, .pointer_bit8_clock_enable,
		.pointer_bit8_clock, .external_branch_field, .buffer_clock, .count_step, .count_load,
		.code_decode, .carry_flag_clock, .overflow_flag_clock, .neg_zero_flag_clock,
		.neg_zero_mux_select, .carry_overflow_mux_select, .divisor_reg_select, .read_mux_select,
		.read_mux_strobe, .bus_rd_n_o, .bus_rd_n_oe, .bus_u_n_o, .bus_u_n_oe, .fp_high_shift_reg,
		.fp_low_shift_reg);

	task automatic check(input logic [95:0] seen, input logic [95:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// Returns just after the edge at which the option microword is clocked
	task automatic wait_load();
		for (int k = 0; k < 8; k++) begin
			@(posedge ref_clk);
			if (microword_clock === 1'h1) break;
		end
		#1;
	endtask : wait_load

	task automatic run_row(input omf_row_t r, input logic frc);
		logic [23:0] mw;
		mw = r.base | (24'(r.code) << 7);
		ustore_data = mw;
		fp_store_data = r.fp;
		option_buffer_register = r.buf_v;
		read_word = ~r.buf_v;
		host_format_word = {28'hFFF_FFFF, r.buf_v};
		argument_even_force = frc;
		divisor_bit0 = r.dbit;
		external_carry_flag = r.cin;
		wait_load();
		fp_store_data = 3'h0;
		wait_load();
		tick(2);
		check(external_branch_field, mw[3:0]);
		check(code_decode, 8'h01 << r.code);
		check({neg_zero_mux_select, carry_overflow_mux_select}, {mw[14:13], mw[17:15]});
		check(divisor_reg_select, mw[19:18]);
		check({read_mux_strobe, read_mux_select}, mw[22:20]);
		check(bus_rd_n_oe, mw[22] ? read_word : 16'h0000);
		check(host_uword, {28'h000_0000, r.buf_v & ~(16'(frc) << 9)});
		check(fp_high_shift_reg, r.hi);
		check(fp_low_shift_reg, r.lo);
	endtask : run_row

	// Pulses of each strobe over two whole microcycles, one nibble per strobe
	task automatic count_pulses(input logic [27:0] exp);
		logic [27:0] cnt;
		cnt = '0;
		wait_load();
		wait_load();
		tick(2);
		repeat (8) begin
			tick(1);
			cnt += {4'(count_step), 4'(count_load), 4'(buffer_clock), 4'(carry_flag_clock),
			        4'(overflow_flag_clock), 4'(neg_zero_flag_clock), 4'(pointer_bit8_clock)};
		end
		check(cnt, exp);
	endtask : count_pulses

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		#10000;
		num_errors++;
		report_and_stop();
	end

	initial begin
		resetn = 1'h0;
		microprogram_page_bit = 1'h0;
		ustore_data = '0;
		ustore_bit8_enable = 1'h0;
		fp_store_data = 3'h0;
		host_format_word = '0;
		argument_even_force = 1'h0;
		read_word = '0;
		option_buffer_register = '0;
		external_carry_flag = 1'h0;
		divisor_bit0 = 1'h0;
		tick(5);
		check({option_store_select, code_decode, bus_rd_n_oe, bus_u_n_oe}, '0);
		check({fp_high_shift_reg, fp_low_shift_reg, bus_u_n_o, bus_rd_n_o}, '0);
		tick(1);
		resetn = 1'h1;
		microprogram_page_bit = 1'h1;
		tick(2);
		foreach (rows[i]) run_row(rows[i], 1'(i));
		ustore_data = 24'h00_1C70;
		ustore_bit8_enable = 1'h1;
		count_pulses(28'h242_4442);
		check(pointer_bit8_clock_enable, 1'h1);
		ustore_data = 24'h00_0000;
		ustore_bit8_enable = 1'h0;
		count_pulses(28'h000_0000);
		// Page bit low: store disabled, microword must not change
		microprogram_page_bit = 1'h0;
		ustore_data = 24'h00_0380;
		repeat (3) wait_load();
		tick(2);
		check(option_store_select, 1'h0);
		check(code_decode, 8'h01);
		check(bus_u_n_oe, '0);
		check(host_uword, HOST_PATTERN);
		microprogram_page_bit = 1'h1;
		repeat (3) wait_load();
		tick(2);
		check(code_decode, 8'h80);
		report_and_stop();
	end
endmodule : tb_top
